// >>> cs_pkg.sv
// How it works
// - Pin A high, B low selects channel one
// - LED1 red steady off; 1/10 Hz errors
// - LED1 green steady on; 1 Hz weak
// - LED2 dark unless interlock waits for release
// - LED2 steady yellow when release is possible
// - LED2 blinks upstream open; 1x/2x changeover
// - LED3 dark without special function
// - LED3 steady blue after blanking taught
// - LED3 blue 1 Hz while muting
// - LED3 short blue flash teach, restart, override
// - LED3 blue 10 Hz on teach error
`default_nettype none
package cs_pkg;
	// Register bus
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam logic [7:0]  OFF_STATE     = 8'h00;
	localparam logic [7:0]  OFF_IRQ_STAT  = 8'h04;
	localparam logic [7:0]  OFF_IRQ_MASK  = 8'h08;
	localparam logic [7:0]  OFF_CTRL      = 8'h0c;
	// Control register
	localparam int          CTRL_EN_BIT   = 0;
	localparam logic        CTRL_EN_RESET = 1'h1;
	// Event bits of status and mask
	localparam int          IRQ_W         = 6;
	localparam int          EV_EXT_ERR    = 0;
	localparam int          EV_INT_ERR    = 1;
	localparam int          EV_TEACH_ERR  = 2;
	localparam int          EV_UPSTREAM   = 3;
	localparam int          EV_CHANNEL    = 4;
	localparam int          EV_OUT_OFF    = 5;
	localparam logic [5:0]  MASK_RESET    = 6'h00;
	// State word bit positions
	localparam int          ST_RED        = 0;
	localparam int          ST_GREEN      = 1;
	localparam int          ST_YELLOW     = 2;
	localparam int          ST_BLUE       = 3;
	localparam int          ST_CHAN_LO    = 4;
	localparam int          ST_CHG_BUSY   = 6;
	// Transmission channel codes
	localparam logic [1:0]  CH_NONE       = 2'h0;
	localparam logic [1:0]  CH_ONE        = 2'h1;
	localparam logic [1:0]  CH_TWO        = 2'h2;
	// Timing
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          TICK_MS       = 50;
	localparam int          TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int          CNT_W         = 24;
	localparam int          PH_W          = 5;
	localparam logic [4:0]  TICKS_PER_SEC = 5'h14;
	localparam logic [4:0]  SLOW_ON_TICKS = 5'h0a;
	localparam logic [2:0]  CHG_PH_TICKS  = 3'h4;
	// Changeover blink sequencer
	typedef enum logic [1:0] {
		CHG_IDLE = 2'b00,
		CHG_ON   = 2'b01,
		CHG_OFF  = 2'b10
	} cs_chg_t;
endpackage
`default_nettype wire

// >>> cs_blink_if.sv
`default_nettype none
interface cs_blink_if;
	logic tick;
	logic fast;
	logic slow;
	logic shrt;
	modport src (output tick, output fast, output slow, output shrt);
	modport snk (input tick, input fast, input slow, input shrt);
endinterface
`default_nettype wire

// >>> cs_blink_gen.sv
`default_nettype none
module cs_blink_gen #(
	parameter int unsigned TICK_CYCLES = cs_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic  core_clk_in,
	input  wire logic  reset_n_in,
	// Blink phases
	cs_blink_if.src    bl
);
	typedef struct packed {
		logic [cs_pkg::CNT_W-1:0] cnt;
		logic [cs_pkg::PH_W-1:0]  ph;
		logic                     tick;
	} cs_blink_st_t;

	cs_blink_st_t s;
	cs_blink_st_t next_s;

	// One 50 ms tick; every rate is a phase of the same count so they stay aligned
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == cs_pkg::CNT_W'(TICK_CYCLES - 1)) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
			if (s.ph == cs_pkg::TICKS_PER_SEC - 5'h01) begin
				next_s.ph = '0;
			end else begin
				next_s.ph = s.ph + 5'h01;
			end
		end else begin
			next_s.cnt = s.cnt + 24'h000001;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign bl.tick = s.tick;
	assign bl.fast = s.ph[0];
	assign bl.slow = s.ph < cs_pkg::SLOW_ON_TICKS;
	assign bl.shrt = s.ph == 5'h00;

	property p_phase_range;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ph < cs_pkg::TICKS_PER_SEC && (!s.tick || s.cnt == '0);
	endproperty
	a_phase_range: assert property (p_phase_range)
		else $error("Blink phase out of range");
endmodule
`default_nettype wire

// >>> cs_status_top.sv
// Chosen here: strobed register access and the address map.
`default_nettype none
module cs_status_top #(
	parameter int unsigned TICK_CYCLES = cs_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	// Register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	output logic             irq_out,
	// Supply polarity
	input  wire logic        supply_pin_a_in,
	input  wire logic        supply_pin_b_in,
	output logic      [1:0]  channel_sel_out,
	// Safety output and errors
	input  wire logic        safety_switch_output_on_in,
	input  wire logic        external_error_in,
	input  wire logic        internal_error_in,
	input  wire logic        weak_signal_in,
	// Restart interlock and upstream circuit
	input  wire logic        restart_interlock_active_in,
	input  wire logic        restart_interlock_blocked_in,
	input  wire logic        field_free_in,
	input  wire logic        linked_sensor_ok_in,
	input  wire logic        upstream_open_in,
	input  wire logic        upstream_change_in,
	input  wire logic        upstream_change_two_in,
	// Special functions
	input  wire logic        teach_done_in,
	input  wire logic        teaching_in,
	input  wire logic        teach_error_in,
	input  wire logic        muting_active_in,
	input  wire logic        muting_restart_req_in,
	input  wire logic        muting_override_in,
	// Indicators
	output logic             led1_red_out,
	output logic             led1_green_out,
	output logic             led2_yellow_out,
	output logic             led3_blue_out
);
	typedef struct packed {
		logic [31:0]    rdata;
		logic           irq;
		logic           red;
		logic           green;
		logic           yellow;
		logic           blue;
		logic [1:0]     chan;
		logic           ctrl_en;
		logic [5:0]     stat;
		logic [5:0]     mask;
		cs_pkg::cs_chg_t chg;
		logic [1:0]     chg_n;
		logic [2:0]     chg_t;
		logic           p_ext;
		logic           p_int;
		logic           p_terr;
		logic           p_on;
	} cs_top_st_t;

	cs_top_st_t s;
	cs_top_st_t next_s;
	logic [5:0] ev;
	logic [1:0] new_chan;
	logic [31:0] state_word;

	cs_blink_if blk ();

	cs_blink_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_blink (
		.core_clk_in (core_clk_in),
		.reset_n_in  (reset_n_in),
		.bl          (blk)
	);

	function automatic logic phase_done(input logic [2:0] t);
		phase_done = t == cs_pkg::CHG_PH_TICKS - 3'h1;
	endfunction

	function automatic logic [31:0] widen6(input logic [5:0] v);
		widen6 = {26'h0000000, v};
	endfunction

	// Both pins at the same level is no valid polarity: the last channel holds
	always_comb begin
		if (supply_pin_a_in && !supply_pin_b_in) begin
			new_chan = cs_pkg::CH_ONE;
		end else if (!supply_pin_a_in && supply_pin_b_in) begin
			new_chan = cs_pkg::CH_TWO;
		end else begin
			new_chan = s.chan;
		end
	end

	always_comb begin
		ev = '0;
		ev[cs_pkg::EV_EXT_ERR] = external_error_in && !s.p_ext;
		ev[cs_pkg::EV_INT_ERR] = internal_error_in && !s.p_int;
		ev[cs_pkg::EV_TEACH_ERR] = teach_error_in && !s.p_terr;
		ev[cs_pkg::EV_UPSTREAM] = upstream_change_in;
		ev[cs_pkg::EV_CHANNEL] = new_chan != s.chan;
		ev[cs_pkg::EV_OUT_OFF] = s.p_on && !safety_switch_output_on_in;
	end

	always_comb begin
		state_word = '0;
		state_word[cs_pkg::ST_RED] = s.red;
		state_word[cs_pkg::ST_GREEN] = s.green;
		state_word[cs_pkg::ST_YELLOW] = s.yellow;
		state_word[cs_pkg::ST_BLUE] = s.blue;
		state_word[cs_pkg::ST_CHAN_LO +: 2] = s.chan;
		state_word[cs_pkg::ST_CHG_BUSY] = s.chg != cs_pkg::CHG_IDLE;
	end

	always_comb begin
		next_s = s;
		next_s.rdata = '0;
		next_s.chan = new_chan;
		next_s.p_ext = external_error_in;
		next_s.p_int = internal_error_in;
		next_s.p_terr = teach_error_in;
		next_s.p_on = safety_switch_output_on_in;

		// Register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				cs_pkg::OFF_IRQ_STAT: next_s.stat = s.stat & ~reg_wdata_in[5:0];
				cs_pkg::OFF_IRQ_MASK: next_s.mask = reg_wdata_in[5:0];
				cs_pkg::OFF_CTRL:     next_s.ctrl_en = reg_wdata_in[cs_pkg::CTRL_EN_BIT];
				default:              next_s.ctrl_en = s.ctrl_en;
			endcase
		end
		// A new event beats a clear in the same cycle
		next_s.stat = next_s.stat | ev;
		next_s.irq = |(next_s.stat & next_s.mask);

		// Register reads, answered in the following cycle
		if (reg_rd_in) begin
			case (reg_addr_in)
				cs_pkg::OFF_STATE:    next_s.rdata = state_word;
				cs_pkg::OFF_IRQ_STAT: next_s.rdata = widen6(s.stat);
				cs_pkg::OFF_IRQ_MASK: next_s.rdata = widen6(s.mask);
				cs_pkg::OFF_CTRL:     next_s.rdata = {31'h00000000, s.ctrl_en};
				default:              next_s.rdata = '0;
			endcase
		end

		// Changeover blinks; a new changeover while busy is not queued
		unique case (s.chg)
			cs_pkg::CHG_IDLE: begin
				if (upstream_change_in) begin
					next_s.chg = cs_pkg::CHG_ON;
					next_s.chg_n = upstream_change_two_in ? 2'h2 : 2'h1;
					next_s.chg_t = '0;
				end
			end
			cs_pkg::CHG_ON: begin
				if (blk.tick) begin
					if (phase_done(s.chg_t)) begin
						next_s.chg = cs_pkg::CHG_OFF;
						next_s.chg_t = '0;
					end else begin
						next_s.chg_t = s.chg_t + 3'h1;
					end
				end
			end
			cs_pkg::CHG_OFF: begin
				if (blk.tick) begin
					if (!phase_done(s.chg_t)) begin
						next_s.chg_t = s.chg_t + 3'h1;
					end else if (s.chg_n == 2'h1) begin
						next_s.chg = cs_pkg::CHG_IDLE;
						next_s.chg_t = '0;
					end else begin
						next_s.chg = cs_pkg::CHG_ON;
						next_s.chg_n = s.chg_n - 2'h1;
						next_s.chg_t = '0;
					end
				end
			end
			// Unused code falls back to idle rather than locking the lamp
			default: next_s.chg = cs_pkg::CHG_IDLE;
		endcase

		// LED 1: errors first, then output state
		next_s.red = 1'b0;
		next_s.green = 1'b0;
		if (internal_error_in) begin
			next_s.red = blk.fast;
		end else if (external_error_in) begin
			next_s.red = blk.slow;
		end else if (!safety_switch_output_on_in) begin
			next_s.red = 1'b1;
		end else if (weak_signal_in) begin
			next_s.green = blk.slow;
		end else begin
			next_s.green = 1'b1;
		end

		// LED 2: a changeover sequence owns the lamp until it ends
		if (s.chg != cs_pkg::CHG_IDLE) begin
			next_s.yellow = s.chg == cs_pkg::CHG_ON;
		end else if (upstream_open_in) begin
			next_s.yellow = blk.slow;
		end else begin
			next_s.yellow = restart_interlock_active_in && restart_interlock_blocked_in &&
				field_free_in && linked_sensor_ok_in;
		end

		// LED 3: teach error first
		if (teach_error_in) begin
			next_s.blue = blk.fast;
		end else if (teaching_in || muting_restart_req_in || muting_override_in) begin
			next_s.blue = blk.shrt;
		end else if (muting_active_in) begin
			next_s.blue = blk.slow;
		end else begin
			next_s.blue = teach_done_in;
		end

		// Display disable blanks all lamps, events still recorded
		if (!s.ctrl_en) begin
			next_s.red = 1'b0;
			next_s.green = 1'b0;
			next_s.yellow = 1'b0;
			next_s.blue = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			s <= '0;
			s.ctrl_en <= cs_pkg::CTRL_EN_RESET;
			s.mask <= cs_pkg::MASK_RESET;
			s.chan <= cs_pkg::CH_NONE;
			s.chg <= cs_pkg::CHG_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata_out = s.rdata;
	assign irq_out = s.irq;
	assign channel_sel_out = s.chan;
	assign led1_red_out = s.red;
	assign led1_green_out = s.green;
	assign led2_yellow_out = s.yellow;
	assign led3_blue_out = s.blue;

	property p_channel;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		supply_pin_a_in != supply_pin_b_in |=>
			channel_sel_out == ($past(supply_pin_a_in) ? cs_pkg::CH_ONE : cs_pkg::CH_TWO);
	endproperty
	a_channel: assert property (p_channel)
		else $error("Channel does not follow supply polarity");

	property p_internal_error;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ctrl_en && internal_error_in |=> led1_red_out == $past(blk.fast) && !led1_green_out;
	endproperty
	a_internal_error: assert property (p_internal_error)
		else $error("Internal error not shown as fast red");

	property p_external_error;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ctrl_en && external_error_in && !internal_error_in |=>
			led1_red_out == $past(blk.slow) && !led1_green_out;
	endproperty
	a_external_error: assert property (p_external_error)
		else $error("External error not shown as slow red");

	property p_outputs_on;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ctrl_en && !internal_error_in && !external_error_in && safety_switch_output_on_in |=>
			!led1_red_out && led1_green_out == ($past(weak_signal_in) ? $past(blk.slow) : 1'b1);
	endproperty
	a_outputs_on: assert property (p_outputs_on)
		else $error("Green indication wrong with outputs on");

	property p_interlock_dark;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.chg == cs_pkg::CHG_IDLE && !upstream_open_in &&
			(!restart_interlock_active_in || !restart_interlock_blocked_in || !field_free_in) |=> !led2_yellow_out;
	endproperty
	a_interlock_dark: assert property (p_interlock_dark)
		else $error("Yellow lit without release possible");

	property p_interlock_ready;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ctrl_en && s.chg == cs_pkg::CHG_IDLE && !upstream_open_in && restart_interlock_active_in &&
			restart_interlock_blocked_in && field_free_in && linked_sensor_ok_in |=> led2_yellow_out;
	endproperty
	a_interlock_ready: assert property (p_interlock_ready)
		else $error("Yellow not steady when release possible");

	property p_changeover;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.chg == cs_pkg::CHG_IDLE && upstream_change_in |=>
			s.chg == cs_pkg::CHG_ON && s.chg_n == ($past(upstream_change_two_in) ? 2'h2 : 2'h1);
	endproperty
	a_changeover: assert property (p_changeover)
		else $error("Changeover blink count not loaded");

	property p_blue_dark;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!teach_error_in && !teaching_in && !muting_restart_req_in && !muting_override_in &&
			!muting_active_in && !teach_done_in |=> !led3_blue_out;
	endproperty
	a_blue_dark: assert property (p_blue_dark)
		else $error("Blue lit without special function");

	property p_taught;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ctrl_en && teach_done_in && !teach_error_in && !teaching_in && !muting_restart_req_in &&
			!muting_override_in && !muting_active_in |=> led3_blue_out;
	endproperty
	a_taught: assert property (p_taught)
		else $error("Blue not steady after teaching");

	property p_muting;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ctrl_en && muting_active_in && !teach_error_in && !teaching_in && !muting_restart_req_in &&
			!muting_override_in |=> led3_blue_out == $past(blk.slow);
	endproperty
	a_muting: assert property (p_muting)
		else $error("Muting not shown as slow blue");

	property p_short_flash;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ctrl_en && !teach_error_in && (teaching_in || muting_restart_req_in || muting_override_in)
			|=> led3_blue_out == $past(blk.shrt);
	endproperty
	a_short_flash: assert property (p_short_flash)
		else $error("Short blue flash missing");

	property p_teach_error;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s.ctrl_en && teach_error_in |=> led3_blue_out == $past(blk.fast);
	endproperty
	a_teach_error: assert property (p_teach_error)
		else $error("Teach error not shown as fast blue");
endmodule
`default_nettype wire

// >>> cs_wiring_model.sv
`default_nettype none
module cs_wiring_model (
	// Clock
	input  wire logic        core_clk_in,
	// Operator and wiring requests
	input  wire logic [18:0] req_in,
	// Levels toward the receiver
	output logic      [18:0] lvl_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Contacts change only after an edge, so the receiver never sees a mid-edge glitch
	always @(posedge core_clk_in) begin
		lvl_out <= req_in;
	end
endmodule
`default_nettype wire

// >>> test_curtain_status_indicator.sv
`default_nettype none
module test_curtain_status_indicator;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int   TK       = 4;
	localparam int   SEC      = 20 * TK;
	localparam int   LIT[5]   = '{0, SEC, SEC / 2, SEC / 2, TK};
	localparam int   TOG[5]   = '{0, 0, 2, 20, 2};
	localparam logic [1:0] PINS[5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1};
	localparam logic [1:0] CHS[5]  = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h1};
	logic        core_clk_in  = 1'b0;
	logic        reset_n_in   = 1'b0;
	logic [7:0]  reg_addr_in  = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in    = 1'b0;
	logic        reg_rd_in    = 1'b0;
	logic [31:0] reg_rdata_out;
	logic        irq_out;
	logic [1:0]  channel_sel_out;
	logic [3:0]  led;
	logic [18:0] req          = 19'h0;
	logic [18:0] lvl;
	logic [31:0] rd;
	int          num_errors   = 0;
	int          checks       = 0;
	int          cyc          = 0;
	always #2 core_clk_in = ~core_clk_in;
	cs_wiring_model i_cs_wiring_model (.core_clk_in(core_clk_in), .req_in(req), .lvl_out(lvl));
	cs_status_top #(.TICK_CYCLES(TK)) i_cs_status_top (
		.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .supply_pin_a_in(lvl[0]),
		.supply_pin_b_in(lvl[1]), .channel_sel_out(channel_sel_out), .safety_switch_output_on_in(lvl[2]),
		.external_error_in(lvl[3]), .internal_error_in(lvl[4]), .weak_signal_in(lvl[5]),
		.restart_interlock_active_in(lvl[6]), .restart_interlock_blocked_in(lvl[7]),
		.field_free_in(lvl[8]), .linked_sensor_ok_in(lvl[9]), .upstream_open_in(lvl[10]),
		.upstream_change_in(lvl[11]), .upstream_change_two_in(lvl[12]), .teach_done_in(lvl[13]),
		.teaching_in(lvl[14]), .teach_error_in(lvl[15]), .muting_active_in(lvl[16]),
		.muting_restart_req_in(lvl[17]), .muting_override_in(lvl[18]), .led1_red_out(led[0]),
		.led1_green_out(led[1]), .led2_yellow_out(led[2]), .led3_blue_out(led[3]));
	task automatic conclude();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask
	task automatic apply(input logic [18:0] v);
		@(posedge core_clk_in);
		req <= v;
		repeat (4) @(posedge core_clk_in);
		#1;
	endtask
	// Lamp modes: 0 off, 1 steady, 2 slow, 3 fast, 4 short flash
	function automatic int exp_mode(input logic [18:0] v, input int l);
		case (l)
			0: return v[4] ? 3 : v[3] ? 2 : !v[2] ? 1 : 0;
			1: return (v[4] | v[3] | !v[2]) ? 0 : v[5] ? 2 : 1;
			2: return v[10] ? 2 : (v[6] & v[7] & v[8] & v[9]) ? 1 : 0;
			default: return v[15] ? 3 : (v[14] | v[17] | v[18]) ? 4 : v[16] ? 2 : v[13] ? 1 : 0;
		endcase
	endfunction
	// One full blink period, so counts do not depend on divider phase
	task automatic measure(input logic [18:0] v, input logic en);
		int         lit[4];
		int         tog[4];
		int         m;
		logic [3:0] prev;
		prev = led;
		for (int i = 0; i < SEC; i++) begin
			@(posedge core_clk_in);
			#1;
			for (int l = 0; l < 4; l++) begin
				lit[l] += led[l];
				tog[l] += (led[l] != prev[l]);
			end
			prev = led;
		end
		for (int l = 0; l < 4; l++) begin
			m = en ? exp_mode(v, l) : 0;
			chk(lit[l], LIT[m]);
			chk(tog[l], TOG[m]);
		end
	endtask
	initial begin
		logic [18:0] v;
		int          cnt;
		logic        p;
		void'($urandom(32'hc86b3eb3));
		repeat (6) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		#1;
		chk(32'({irq_out, channel_sel_out, led}), 32'h0);
		rdr(cs_pkg::OFF_CTRL, rd);
		chk(rd, 32'h1);
		rdr(cs_pkg::OFF_IRQ_MASK, rd);
		chk(rd, 32'h0);
		wr(cs_pkg::OFF_IRQ_MASK, 32'h3f);
		wr(8'h10, 32'hffffffff);
		rdr(cs_pkg::OFF_IRQ_MASK, rd);
		chk(rd, 32'h3f);
		rdr(8'h10, rd);
		chk(rd, 32'h0);
		$display("registers done");
		for (int i = 0; i < 5; i++) begin
			apply({17'h1, PINS[i]});
			chk(channel_sel_out, CHS[i]);
		end
		rdr(cs_pkg::OFF_STATE, rd);
		chk(rd[5:4], CHS[4]);
		$display("channel done");
		for (int t = 0; t < 24; t++) begin
			v = 19'($urandom) & ~19'h1800;
			apply(v);
			measure(v, 1'b1);
			$display("lamp test %0d done", t);
		end
		for (int n = 1; n <= 2; n++) begin
			apply(19'h4);
			@(posedge core_clk_in);
			req <= (n == 2) ? 19'h1804 : 19'h0804;
			@(posedge core_clk_in);
			req <= 19'h4;
			cnt = 0;
			p   = 1'b0;
			repeat (100) begin
				@(posedge core_clk_in);
				#1;
				cnt += (led[2] && !p);
				p = led[2];
			end
			chk(cnt, n);
			$display("changeover %0d done", n);
		end
		wr(cs_pkg::OFF_CTRL, 32'h0);
		v = 19'($urandom) & ~19'h1800;
		apply(v);
		measure(v, 1'b0);
		wr(cs_pkg::OFF_CTRL, 32'h1);
		$display("display enable done");
		apply(19'h4);
		rdr(cs_pkg::OFF_STATE, rd);
		chk(rd[3:0], 4'h2);
		chk(rd[6], 1'b0);
		wr(cs_pkg::OFF_IRQ_MASK, 32'h0);
		wr(cs_pkg::OFF_IRQ_STAT, 32'h3f);
		rdr(cs_pkg::OFF_IRQ_STAT, rd);
		chk(rd, 32'h0);
		apply(19'hc);
		rdr(cs_pkg::OFF_IRQ_STAT, rd);
		chk(rd, 32'h1 << cs_pkg::EV_EXT_ERR);
		chk(irq_out, 1'b0);
		wr(cs_pkg::OFF_IRQ_MASK, 32'h1 << cs_pkg::EV_EXT_ERR);
		chk(irq_out, 1'b1);
		wr(cs_pkg::OFF_IRQ_STAT, 32'h1 << cs_pkg::EV_EXT_ERR);
		chk(irq_out, 1'b0);
		$display("interrupt done");
		conclude();
	end
endmodule
`default_nettype wire
